// *** src/cpsm_consts.vh ***
// Constants for the configuration port status monitor.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef CPSM_CONSTS_VH
`define CPSM_CONSTS_VH

// Register byte offsets
`define CPSM_OFF_STATUS   8'h00
`define CPSM_OFF_EVENT    8'h04
`define CPSM_OFF_CLEAR    8'h08
`define CPSM_OFF_ENABLE   8'h0C
`define CPSM_OFF_CONTROL  8'h10

// Status byte field positions
`define CPSM_BIT_ERR_N    7
`define CPSM_BIT_SYNC     6
`define CPSM_BIT_RDBK     5
`define CPSM_BIT_ABORT_N  4

// Reserved low nibble and reset values
`define CPSM_RSVD_NIBBLE  4'hF
`define CPSM_STATUS_IDLE  8'h9F
`define CPSM_ENABLE_RST   4'h0

// Event bit positions
`define CPSM_EV_SYNC      0
`define CPSM_EV_ERROR     1
`define CPSM_EV_DONE      2
`define CPSM_EV_FRAME     3

// AXI responses
`define CPSM_RESP_OKAY    2'h0
`define CPSM_RESP_SLVERR  2'h2

`endif

// *** src/cpsm_monitor.v ***
// Status monitor of the internal configuration port: status byte, done and fault mirrors.
// Assumes bitstream decode events arrive on core_clk_i; done pin arrives asynchronously.
//
// Functional notes
// [RQ1] 32-bit status word, low byte meaningful
// [RQ2] Bit 7 low once configuration error occurred
// [RQ3] Bit 6 high after sync word received
// [RQ4] Bit 5 high during readback
// [RQ5] Bit 4 low while abort in progress
// [RQ6] Bits 3..0 reserved, decoders ignore
// [RQ7] Upper nibble 9, D, 5, 1 encodings
// [RQ8] Idle 9F, then DF on sync
// [RQ9] CRC error: 5F one cycle, 1F, fault
// [RQ10] CRC reset clears error and fault
// [RQ11] Reload: 1F to 5F on sync
// [RQ12] Reload: 5F to DF on CRC reset
// [RQ13] End session without error returns 9F
// [RQ14] Done output mirrors external done pin
// [RQ15] Controller uses startup end for slave dies
// [RQ16] Fault mirrors init, any CRC error
// [RQ17] Controller recovers by reloading bitstream
// [RQ18] Per-frame CRC failure blocks frame write
// [RQ19] Controller decodes bits 7..4 only
`timescale 1ns/100ps
`default_nettype none
`include "cpsm_consts.vh"

module cpsm_monitor (
    input  wire        core_clk_i,       // Configuration clock, 10 MHz
    input  wire        srst_i,           // Synchronous reset, active high
    input  wire        sync_word_i,      // Pulse: sync word detected
    input  wire        crc_fail_i,       // Pulse: whole-file CRC check failed
    input  wire        frame_crc_fail_i, // Pulse: per-frame CRC check failed
    input  wire        crc_reset_cmd_i,  // Pulse: CRC reset command
    input  wire        end_session_cmd_i,// Pulse: end-of-session command
    input  wire        readback_i,       // Level: readback in progress
    input  wire        abort_i,          // Level: abort in progress
    input  wire        frame_wr_i,       // Pulse: frame ready to commit
    input  wire        done_pin_i,       // External done pin, asynchronous
    output reg  [31:0] status_o,         // Status word, low byte used
    output reg         partial_load_done_o,  // Mirror of done pin
    output reg         partial_load_fault_o, // Mirror of init pin, low on fault
    output reg         init_drive_low_o, // Init pin pull-down request
    output reg         frame_commit_o,   // Frame write to configuration memory
    output reg         irq_o,            // Level interrupt
    input  wire [7:0]  s_axi_awaddr,     // Write address
    input  wire        s_axi_awvalid,    // Write address valid
    output reg         s_axi_awready,    // Write address ready
    input  wire [31:0] s_axi_wdata,      // Write data
    input  wire [3:0]  s_axi_wstrb,      // Write strobes
    input  wire        s_axi_wvalid,     // Write data valid
    output reg         s_axi_wready,     // Write data ready
    output reg  [1:0]  s_axi_bresp,      // Write response
    output reg         s_axi_bvalid,     // Write response valid
    input  wire        s_axi_bready,     // Write response ready
    input  wire [7:0]  s_axi_araddr,     // Read address
    input  wire        s_axi_arvalid,    // Read address valid
    output reg         s_axi_arready,    // Read address ready
    output reg  [31:0] s_axi_rdata,      // Read data
    output reg  [1:0]  s_axi_rresp,      // Read response
    output reg         s_axi_rvalid,     // Read data valid
    input  wire        s_axi_rready      // Read data ready
);

    // ==========================================================
    // Core state
    // ==========================================================
    reg        synced;
    reg        err_latched;
    reg        err_flash;      // One-cycle sync-with-error display
    reg        frame_crc_en;   // Control: per-frame CRC checking
    reg        done_meta;
    reg        done_sync;
    reg [3:0]  ev_status;
    reg [3:0]  ev_enable;
    reg [3:0]  ev_clear;       // Write-only clear pulse
    reg        next_synced;
    reg        next_err;
    reg        crc_event;
    wire [7:0] status_byte;
    wire [3:0] ev_set;

    // ==========================================================
    // Next sync and error state
    // ==========================================================
    // Any CRC error, whole-file or per-frame when enabled
    always @* begin
        crc_event = crc_fail_i | (frame_crc_fail_i & frame_crc_en); // RQ16
    end

    // Next sync and error state
    always @* begin
        next_synced = synced;
        next_err    = err_latched;
        if (sync_word_i) begin
            next_synced = 1'b1;                          // RQ3 RQ8 RQ11
        end
        if (crc_reset_cmd_i) begin
            next_err = 1'b0;                             // RQ10 RQ12
        end
        if (end_session_cmd_i) begin
            next_synced = 1'b0;                          // RQ13
        end
        if (crc_event) begin
            next_err    = 1'b1;                          // RQ9
            next_synced = 1'b0;                          // RQ9
        end
    end

    // ==========================================================
    // Sync and error registers
    // ==========================================================
    // Error wins over sync, reset and end in one cycle
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            synced      <= 1'b0;
            err_latched <= 1'b0;
            err_flash   <= 1'b0;
        end else begin
            synced      <= next_synced;
            err_latched <= next_err;
            err_flash   <= crc_event & synced;           // RQ9
        end
    end

    // ==========================================================
    // Status byte fields
    // ==========================================================
    wire       fld_err_n;      // Bit 7, low once an error is latched
    wire       fld_sync;       // Bit 6, sync word seen
    wire       fld_rdbk;       // Bit 5, readback running
    wire       fld_abort_n;    // Bit 4, low while aborting
    wire [3:0] fld_rsvd;       // Bits 3..0, reserved

    // Flash shows sync-with-error for exactly one cycle
    assign fld_err_n   = ~(err_latched | err_flash);       // RQ2 RQ7 RQ9
    assign fld_sync    = synced | err_flash;               // RQ3 RQ7 RQ9

    // Readback and abort follow their levels
    assign fld_rdbk    = readback_i;                       // RQ4
    assign fld_abort_n = ~abort_i;                         // RQ5

    // Reserved nibble, decoders must ignore it
    assign fld_rsvd    = `CPSM_RSVD_NIBBLE;                // RQ6

    // Assemble the byte in field order
    assign status_byte[`CPSM_BIT_ERR_N]   = fld_err_n;
    assign status_byte[`CPSM_BIT_SYNC]    = fld_sync;
    assign status_byte[`CPSM_BIT_RDBK]    = fld_rdbk;
    assign status_byte[`CPSM_BIT_ABORT_N] = fld_abort_n;
    assign status_byte[3:0]               = fld_rsvd;

    // ==========================================================
    // Done pin synchroniser
    // ==========================================================
    // Only the second flop feeds logic
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            done_meta <= done_pin_i;
            done_sync <= done_meta;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    // Fault and init drive follow the next error state
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            status_o             <= {24'h000000, `CPSM_STATUS_IDLE};
            partial_load_done_o  <= 1'b0;
            partial_load_fault_o <= 1'b1;
            init_drive_low_o     <= 1'b0;
            frame_commit_o       <= 1'b0;
        end else begin
            status_o             <= {24'h000000, status_byte};   // RQ1
            partial_load_done_o  <= done_sync;                   // RQ14
            partial_load_fault_o <= ~next_err;                   // RQ16
            init_drive_low_o     <= next_err;                    // RQ9 RQ10
            frame_commit_o       <= frame_wr_i &
                                    ~(frame_crc_en & frame_crc_fail_i); // RQ18
        end
    end

    // ==========================================================
    // Interrupt events
    // ==========================================================
    // Event causes, one per sticky bit
    assign ev_set[`CPSM_EV_SYNC]  = sync_word_i;                        // RQ3
    assign ev_set[`CPSM_EV_ERROR] = crc_event;                          // RQ9
    assign ev_set[`CPSM_EV_DONE]  = done_sync & ~partial_load_done_o;   // RQ14
    assign ev_set[`CPSM_EV_FRAME] = frame_crc_fail_i & frame_crc_en;    // RQ18

    // Sticky status per event, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ev
            always @(posedge core_clk_i) begin
                if (srst_i) begin
                    ev_status[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    ev_status[gi] <= 1'b1;
                end else if (ev_clear[gi]) begin
                    ev_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt from enabled sticky bits
    wire [3:0] ev_pending;     // Sticky bits as they will be next

    assign ev_pending = (ev_status & ~ev_clear) | ev_set;

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_pending & ev_enable);
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write;

    assign do_write = aw_held & w_held & ~s_axi_bvalid;

    wire [7:0] wr_offset;      // Word-aligned write offset
    wire       wr_clear;       // Write to clear register
    wire       wr_enable;      // Write to enable register
    wire       wr_control;     // Write to control register
    wire       wr_mapped;      // Offset holds a register

    // Decode the held write; only the low byte lane carries fields
    assign wr_offset  = {aw_addr[7:2], 2'b00};
    assign wr_clear   = do_write & (wr_offset == `CPSM_OFF_CLEAR) & w_strb[0];
    assign wr_enable  = do_write & (wr_offset == `CPSM_OFF_ENABLE) & w_strb[0];
    assign wr_control = do_write & (wr_offset == `CPSM_OFF_CONTROL) & w_strb[0];
    assign wr_mapped  = (wr_offset == `CPSM_OFF_STATUS) |
                        (wr_offset == `CPSM_OFF_EVENT) |
                        (wr_offset == `CPSM_OFF_CLEAR) |
                        (wr_offset == `CPSM_OFF_ENABLE) |
                        (wr_offset == `CPSM_OFF_CONTROL);

    // Write channel: take address and data in either order
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CPSM_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Read-only offsets take the write silently
                if (wr_mapped) begin
                    s_axi_bresp <= `CPSM_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `CPSM_RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register bank
    // ==========================================================
    // Clear register is write-only and self-clears after a cycle
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ev_enable    <= `CPSM_ENABLE_RST;
            ev_clear     <= 4'h0;
            frame_crc_en <= 1'b0;
        end else begin
            ev_clear <= 4'h0;
            if (wr_clear) begin
                ev_clear <= w_data[3:0];
            end
            if (wr_enable) begin
                ev_enable <= w_data[3:0];
            end
            if (wr_control) begin
                frame_crc_en <= w_data[0];               // RQ18
            end
        end
    end

    // ==========================================================
    // Read data mux
    // ==========================================================
    reg [31:0] next_rdata;     // Data for the accepted read
    reg [1:0]  next_rresp;     // Response for the accepted read
    wire [7:0] rd_offset;      // Word-aligned read offset

    assign rd_offset = {s_axi_araddr[7:2], 2'b00};

    // Unmapped offsets answer zero with an error
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `CPSM_RESP_OKAY;
        case (rd_offset)
            `CPSM_OFF_STATUS: begin
                next_rdata = status_o;                   // RQ1
            end
            `CPSM_OFF_EVENT: begin
                next_rdata = {28'h0000000, ev_status};
            end
            `CPSM_OFF_CLEAR: begin
                next_rdata = 32'h00000000;
            end
            `CPSM_OFF_ENABLE: begin
                next_rdata = {28'h0000000, ev_enable};
            end
            `CPSM_OFF_CONTROL: begin
                next_rdata = {31'h00000000, frame_crc_en};
            end
            default: begin
                next_rresp = `CPSM_RESP_SLVERR;
            end
        endcase
    end

    // Read channel
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CPSM_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rresp;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** verif/cpsm_monitor_asserts.sv ***
// Checker for the status monitor: status byte sequencing, fault, done and frame commit.
// Assumes single clock core_clk_i and synchronous active-high srst_i.
`timescale 1ns/100ps
`default_nettype none
module cpsm_monitor_chk (
    input wire logic        core_clk_i,           // Clock
    input wire logic        srst_i,               // Reset
    input wire logic        sync_word_i,          // Sync pulse
    input wire logic        crc_fail_i,           // CRC fail pulse
    input wire logic        crc_reset_cmd_i,      // CRC reset pulse
    input wire logic        end_session_cmd_i,    // End pulse
    input wire logic        readback_i,           // Readback level
    input wire logic        abort_i,              // Abort level
    input wire logic        frame_wr_i,           // Frame pulse
    input wire logic        frame_crc_fail_i,     // Frame fail pulse
    input wire logic        done_pin_i,           // Done pin
    input wire logic [31:0] status_o,             // Status word
    input wire logic        partial_load_done_o,  // Done mirror
    input wire logic        partial_load_fault_o, // Fault mirror
    input wire logic        init_drive_low_o,     // Init pull-down
    input wire logic        frame_commit_o        // Frame commit
);
    // ==========================================
    // Properties
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    AST_PAD: assert property (status_o[31:8] == 24'h000000 && status_o[3:0] == 4'hF)
        else $error("Status padding wrong");
    AST_SYNC: assert property (sync_word_i && !crc_fail_i && !frame_crc_fail_i
        && !end_session_cmd_i ##1 !crc_fail_i && !frame_crc_fail_i && !end_session_cmd_i
        |=> status_o[6]) else $error("Sync flag not set");
    AST_ERR: assert property (crc_fail_i ##1 !crc_reset_cmd_i |=> !status_o[7])
        else $error("Error flag not set");
    AST_FLASH: assert property (status_o[6] && crc_fail_i ##1 !sync_word_i && !crc_reset_cmd_i
        |=> status_o[7:6] == 2'h1 ##1 status_o[7:6] == 2'h0) else $error("Error flash wrong");
    AST_FAULT: assert property (crc_fail_i ##1 !crc_reset_cmd_i
        |=> !partial_load_fault_o && init_drive_low_o) else $error("Fault not raised");
    AST_CLEAR: assert property (crc_reset_cmd_i && !crc_fail_i && !frame_crc_fail_i
        |=> partial_load_fault_o && !init_drive_low_o ##1 status_o[7])
        else $error("Error not cleared");
    AST_END: assert property (end_session_cmd_i && !sync_word_i && !crc_fail_i
        ##1 !sync_word_i |=> !status_o[6]) else $error("Sync not dropped");
    AST_DONE: assert property (partial_load_done_o == $past(done_pin_i, 3))
        else $error("Done mirror wrong");
    AST_RDBK: assert property (status_o[5] == $past(readback_i) && status_o[4] == !$past(abort_i))
        else $error("Readback or abort flag wrong");
    AST_COMMIT: assert property (frame_wr_i && !frame_crc_fail_i |=> frame_commit_o)
        else $error("Frame not committed");
endmodule
bind cpsm_monitor cpsm_monitor_chk chk_u (.core_clk_i, .srst_i, .sync_word_i, .crc_fail_i,
    .crc_reset_cmd_i, .end_session_cmd_i, .readback_i, .abort_i, .frame_wr_i, .frame_crc_fail_i,
    .done_pin_i, .status_o, .partial_load_done_o, .partial_load_fault_o, .init_drive_low_o,
    .frame_commit_o);
`default_nettype wire

// *** verif/cpsm_ctrl_model.sv ***
// Reconfiguration controller model: issues decode event pulses, decodes status.
// Assumes the monitor samples events on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module cpsm_ctrl_model (
    input  wire logic       clk_i,    // Configuration clock
    input  wire logic [7:0] status_i, // Status byte
    output logic      [5:0] ev_o,     // Event pulses
    output logic            err_o     // Decoded error
);
    // ==========================================
    // Decode bit 7 only
    assign err_o = ~status_i[7];
    initial ev_o = 6'h00;
    // Completion is the end-session step, never the done mirror
    // One-cycle event pulse for recovery steps
    task automatic pulse(input logic [5:0] k);
        @(posedge clk_i);
        ev_o <= k;
        @(posedge clk_i);
        ev_o <= 6'h00;
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Testbench of the status monitor: AXI4-Lite tasks and controller event sequences.
// Assumes the controller model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "cpsm_consts.vh"
module testbench;
    localparam logic [5:0] S = 6'h01, F = 6'h02, P = 6'h04, R = 6'h08, E = 6'h10, W = 6'h20;
    logic        clk = 1'b0, srst = 1'b1, rb = 1'b0, ab = 1'b0, dn = 1'b0, err_seen;
    logic [5:0]  ev;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, status, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pdone, pfault, initlo, commit, irq;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0, checks = 0, cyc = 0;
    // ==========================================
    // Design and partner
    cpsm_monitor dut_u (.core_clk_i(clk), .srst_i(srst), .sync_word_i(ev[0]), .crc_fail_i(ev[1]),
        .frame_crc_fail_i(ev[2]), .crc_reset_cmd_i(ev[3]), .end_session_cmd_i(ev[4]),
        .frame_wr_i(ev[5]), .readback_i(rb), .abort_i(ab), .done_pin_i(dn), .status_o(status),
        .partial_load_done_o(pdone), .partial_load_fault_o(pfault), .init_drive_low_o(initlo),
        .frame_commit_o(commit), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cpsm_ctrl_model ctl_u (.clk_i(clk), .status_i(status[7:0]), .ev_o(ev), .err_o(err_seen));
    // ==========================================
    // Clock and timeout
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            results();
        end
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic st(input logic [7:0] exp);
        @(posedge clk);
        #1 chk(status, {24'h000000, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awready) aw_done = 1'b1;
            if (wready) w_done = 1'b1;
            awvalid <= !aw_done;
            wvalid <= !w_done;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(rresp, er);
    endtask
    task automatic results();
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`CPSM_OFF_STATUS, 32'h9F, 2'h0);
        chk({pfault, initlo, irq}, 32'h4);
        rd(`CPSM_OFF_CONTROL, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h0, 2'h2);
        wr(`CPSM_OFF_ENABLE, 32'h2, 2'h0);
        for (int i = 0; i < 2; i++) begin
            ctl_u.pulse(S);
            st(8'hDF);
            ctl_u.pulse(F);
            st(8'h5F);
            st(8'h1F);
            repeat (2) @(posedge clk);
            #1 chk({pfault, initlo, irq, err_seen}, 32'h7);
            if (i == 0) begin
                rd(`CPSM_OFF_EVENT, 32'h3, 2'h0);
                wr(`CPSM_OFF_CLEAR, 32'h3, 2'h0);
                ctl_u.pulse(R);
                st(8'h9F);
                repeat (2) @(posedge clk);
                #1 chk({pfault, initlo, irq}, 32'h4);
            end
        end
        ctl_u.pulse(S);
        st(8'h5F);
        ctl_u.pulse(R);
        st(8'hDF);
        ctl_u.pulse(E);
        st(8'h9F);
        wr(`CPSM_OFF_ENABLE, 32'h0, 2'h0);
        repeat (2) @(posedge clk);
        #1 chk(irq, 32'h0);
        @(posedge clk);
        rb <= 1'b1;
        st(8'hBF);
        @(posedge clk);
        rb <= 1'b0;
        ab <= 1'b1;
        st(8'h8F);
        @(posedge clk);
        ab <= 1'b0;
        st(8'h9F);
        ctl_u.pulse(W | P);
        #1 chk(commit, 32'h1);
        wr(`CPSM_OFF_CONTROL, 32'h1, 2'h0);
        ctl_u.pulse(W);
        #1 chk(commit, 32'h1);
        ctl_u.pulse(W | P);
        #1 chk(commit, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk(pfault, 32'h0);
        ctl_u.pulse(R);
        @(posedge clk);
        dn <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(pdone, 32'h0);
        @(posedge clk);
        #1 chk(pdone, 32'h1);
        rd(`CPSM_OFF_EVENT, 32'hF, 2'h0);
        results();
    end
endmodule
`default_nettype wire
